// ==== wdt_pkg.sv ====
/*
 * wdt_pkg: register offsets, field positions and reset values of the watchdog.
 * assumes a 32-bit apb register bus, one aligned word per register.
 */
package wdt_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [11:0] OFF_LOAD = 12'h000;
	localparam logic [11:0] OFF_VALUE = 12'h004;
	localparam logic [11:0] OFF_CTRL = 12'h008;
	localparam logic [11:0] OFF_ICR = 12'h00c;
	localparam logic [11:0] OFF_RIS = 12'h010;
	localparam logic [11:0] OFF_MIS = 12'h014;
	localparam logic [11:0] OFF_STALL = 12'h018;
	localparam logic [11:0] OFF_LOCK = 12'h01c;
	localparam logic [11:0] OFF_STATUS = 12'h020;
	localparam logic [11:0] OFF_IMASK = 12'h024;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_INTEN = 0;
	localparam int CTRL_RESEN = 1;
	localparam int CTRL_RUN = 2;
	localparam int ST_TIMEOUT = 0;
	localparam int ST_RESET = 1;

	// ****************************************************************
	// reset values and keys
	// ****************************************************************
	localparam logic [31:0] LOAD_RST = 32'hffffffff;
	localparam logic [31:0] UNLOCK_KEY = 32'h1acce551;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam logic [1:0] ST_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;

endpackage

// ==== wdt_top.sv ====
/*
 * wdt_top: watchdog timer with apb register slave, lock and second-timeout reset.
 * assumes one clock, synchronous inputs, and a debug halt level from the core.
 */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module wdt_top
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic debug_halt,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic wdt_irq,
	output logic wdt_sys_reset
);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_s1_r;
	logic rst_s2_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire logic srst_n = rst_s2_r;

	// ****************************************************************
	// state
	// ****************************************************************
	logic [31:0] load_r;
	logic [31:0] load_nxt;
	logic [31:0] count_r;
	logic [31:0] count_nxt;
	logic run_r;
	logic run_nxt;
	logic inten_r;
	logic inten_nxt;
	logic resen_r;
	logic resen_nxt;
	logic stall_r;
	logic stall_nxt;
	logic locked_r;
	logic locked_nxt;
	logic ris_r;
	logic ris_nxt;
	logic [1:0] st_r;
	logic [1:0] st_nxt;
	logic [1:0] mask_r;
	logic [1:0] mask_nxt;
	logic irq_r;
	logic sysrst_r;

	// ****************************************************************
	// apb decode, zero wait states
	// ****************************************************************
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite;
	wire logic hit_load = paddr == wdt_pkg::OFF_LOAD;
	wire logic hit_value = paddr == wdt_pkg::OFF_VALUE;
	wire logic hit_ctrl = paddr == wdt_pkg::OFF_CTRL;
	wire logic hit_icr = paddr == wdt_pkg::OFF_ICR;
	wire logic hit_ris = paddr == wdt_pkg::OFF_RIS;
	wire logic hit_mis = paddr == wdt_pkg::OFF_MIS;
	wire logic hit_stall = paddr == wdt_pkg::OFF_STALL;
	wire logic hit_lock = paddr == wdt_pkg::OFF_LOCK;
	wire logic hit_stat = paddr == wdt_pkg::OFF_STATUS;
	wire logic hit_mask = paddr == wdt_pkg::OFF_IMASK;
	wire logic mapped = hit_load | hit_value | hit_ctrl | hit_icr | hit_ris | hit_mis
		| hit_stall | hit_lock | hit_stat | hit_mask;
	wire logic full_word = pstrb == 4'hf;
	wire logic wr_ok = wr & mapped & full_word;
	wire logic cfg_open = ~locked_r;
	wire logic wr_load = wr_ok & hit_load & cfg_open;
	wire logic wr_ctrl = wr_ok & hit_ctrl & cfg_open;
	wire logic wr_stall = wr_ok & hit_stall & cfg_open;
	wire logic wr_icr = wr_ok & hit_icr;
	wire logic wr_lock = wr_ok & hit_lock;
	wire logic wr_stat = wr_ok & hit_stat;
	wire logic wr_mask = wr_ok & hit_mask;

	// ****************************************************************
	// counter
	// ****************************************************************
	wire logic halted = stall_r & debug_halt;
	wire logic at_zero = count_r == wdt_pkg::ZERO_WORD;
	wire logic tick = run_r & ~halted;
	wire logic timeout = tick & at_zero;
	wire logic zero_load = wr_load & (pwdata == wdt_pkg::ZERO_WORD);
	wire logic second = timeout & ris_r & resen_r;
	wire logic start = wr_ctrl & pwdata[wdt_pkg::CTRL_RUN] & ~run_r;

	always_comb
	begin
		load_nxt = load_r;
		run_nxt = run_r;
		inten_nxt = inten_r;
		resen_nxt = resen_r;
		stall_nxt = stall_r;
		count_nxt = count_r;
		if (wr_load)
			load_nxt = pwdata;
		if (wr_ctrl)
		begin
			// run and interrupt enable only set; reset enable follows written bit
			if (pwdata[wdt_pkg::CTRL_RUN])
				run_nxt = 1'b1;
			if (pwdata[wdt_pkg::CTRL_RUN] | pwdata[wdt_pkg::CTRL_INTEN])
				inten_nxt = 1'b1;
			resen_nxt = pwdata[wdt_pkg::CTRL_RESEN];
		end
		if (wr_stall)
			stall_nxt = pwdata[0];
		if (tick)
			count_nxt = at_zero ? load_r : count_r - 32'h00000001;
		if (wr_icr)
			count_nxt = load_r; // restart after clear
		if (start)
			count_nxt = load_r;
		if (wr_load & (run_r | start))
			count_nxt = pwdata;
	end

	// ****************************************************************
	// interrupt and status
	// ****************************************************************
	wire logic to_evt = (timeout | zero_load) & inten_nxt;
	always_comb
	begin
		// set wins over clear
		ris_nxt = (ris_r & ~wr_icr) | to_evt;
		st_nxt = st_r & ~(wr_stat ? pwdata[1:0] : 2'h0);
		if (wr_icr)
			st_nxt[wdt_pkg::ST_TIMEOUT] = 1'b0;
		st_nxt[wdt_pkg::ST_TIMEOUT] = st_nxt[wdt_pkg::ST_TIMEOUT] | to_evt;
		st_nxt[wdt_pkg::ST_RESET] = st_nxt[wdt_pkg::ST_RESET] | second;
		mask_nxt = wr_mask ? pwdata[1:0] : mask_r;
		if (wr_lock)
			locked_nxt = pwdata != wdt_pkg::UNLOCK_KEY;
		else
			locked_nxt = locked_r;
	end

	// ****************************************************************
	// read mux
	// ****************************************************************
	wire logic mis = ris_r & inten_r;
	wire logic [31:0] ctrl_rd = {29'h0, run_r, resen_r, inten_r};
	wire logic [31:0] rd_mux =
		hit_load ? load_r :
		hit_value ? count_r :
		hit_ctrl ? ctrl_rd :
		hit_ris ? {31'h0, ris_r} :
		hit_mis ? {31'h0, mis} :
		hit_stall ? {31'h0, stall_r} :
		hit_lock ? {31'h0, locked_r} :
		hit_stat ? {30'h0, st_r} :
		hit_mask ? {30'h0, mask_r} : wdt_pkg::ZERO_WORD;

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			load_r <= wdt_pkg::LOAD_RST;
			count_r <= wdt_pkg::LOAD_RST;
		end
		else
		begin
			load_r <= load_nxt;
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			run_r <= 1'b0;
			inten_r <= 1'b0;
		end
		else
		begin
			run_r <= run_nxt;
			inten_r <= inten_nxt;
		end
	end

	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			resen_r <= 1'b0;
			stall_r <= 1'b0;
		end
		else
		begin
			resen_r <= resen_nxt;
			stall_r <= stall_nxt;
		end
	end

	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			locked_r <= 1'b0;
			mask_r <= wdt_pkg::MASK_RST;
		end
		else
		begin
			locked_r <= locked_nxt;
			mask_r <= mask_nxt;
		end
	end

	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			ris_r <= 1'b0;
			st_r <= wdt_pkg::ST_RST;
		end
		else
		begin
			ris_r <= ris_nxt;
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// bus answer registers
	// ****************************************************************
	wire logic setup_ph = psel & ~penable;
	wire logic rd_take = setup_ph & ~pwrite;

	// read data captured in setup, shown during access
	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
			prdata <= wdt_pkg::ZERO_WORD;
		else
			prdata <= rd_take ? rd_mux : prdata;
	end

	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~mapped;
		end
	end

	// ****************************************************************
	// interrupt and reset outputs
	// ****************************************************************
	always_ff @(posedge clock or negedge srst_n)
	begin
		if (!srst_n)
		begin
			irq_r <= 1'b0;
			sysrst_r <= 1'b0;
		end
		else
		begin
			irq_r <= |(st_nxt & mask_nxt);
			// held until reset of the block itself
			sysrst_r <= sysrst_r | second;
		end
	end

	always_comb
	begin
		wdt_irq = irq_r;
		wdt_sys_reset = sysrst_r;
	end

endmodule

// ==== wdt_top_properties.sv ====
/*
 * wdt_top_properties: port level checks of the watchdog, bound to wdt_top.
 * assumes an apb master that keeps one idle cycle between transfers.
 */
`timescale 1ns/100ps
module wdt_top_properties
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic debug_halt,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wdt_irq,
	input wire logic wdt_sys_reset
);
	// ****************************************************************
	// shadow of lock and reload
	// ****************************************************************
	logic locked_r;
	logic [31:0] load_r;
	wire wr_w = psel && penable && pwrite && pstrb == 4'hf;
	wire rd_w = psel && penable && !pwrite;
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
		begin
			locked_r <= 1'b0;
			load_r <= wdt_pkg::LOAD_RST;
		end
		else if (wr_w)
		begin
			if (paddr == wdt_pkg::OFF_LOCK)
				locked_r <= pwdata != wdt_pkg::UNLOCK_KEY;
			if (paddr == wdt_pkg::OFF_LOAD && !locked_r)
				load_r <= pwdata;
		end
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	a_ready_access: assert property (s_setup |=> pready)
		else $error("no ready in access cycle");
	a_ready_only: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	a_unmapped_err: assert property (s_setup ##0
		(paddr > wdt_pkg::OFF_IMASK || paddr[1:0] != 2'h0)
		|=> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (s_setup ##0
		(paddr <= wdt_pkg::OFF_IMASK && paddr[1:0] == 2'h0) |=> !pslverr)
		else $error("mapped access refused");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_lock_read: assert property (rd_w && paddr == wdt_pkg::OFF_LOCK |-> prdata[0] == locked_r)
		else $error("lock state wrong");
	a_load_read: assert property (rd_w && paddr == wdt_pkg::OFF_LOAD |-> prdata == load_r)
		else $error("reload value wrong");
	a_reset_sticky: assert property (wdt_sys_reset |=> wdt_sys_reset)
		else $error("system reset dropped");
endmodule
bind wdt_top wdt_top_properties u_wdt_top_properties (.clock(clock), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .debug_halt(debug_halt), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .wdt_irq(wdt_irq), .wdt_sys_reset(wdt_sys_reset));

// ==== tb_wdt_top.sv ====
/*
 * tb_wdt_top: apb driven test of the watchdog registers, interrupt and reset.
 * assumes an apb slave that raises pready in its own time.
 */
`timescale 1ns/100ps
module tb_wdt_top;
	// ****************************************************************
	// stimulus and tasks
	// ****************************************************************
	logic clock, rst_n, psel, penable, pwrite, debug_halt, err_v;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd_v, rd_s;
	logic [3:0] pstrb;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, wdt_irq, wdt_sys_reset;
	int bad_count, n_compared;
	wdt_top u_wdt_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.debug_halt(debug_halt), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wdt_irq(wdt_irq), .wdt_sys_reset(wdt_sys_reset));
	always #4 clock = ~clock;
	task automatic tally_and_finish;
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask
	initial
	begin
		repeat (20000) @(posedge clock);
		bad_count++;
		tally_and_finish();
	end
	initial
	begin
		{clock, rst_n, psel, penable, pwrite, debug_halt, paddr, pwdata} = '0;
		pstrb = 4'hf;
		bad_count = 0;
		n_compared = 0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rchk(wdt_pkg::OFF_LOAD, wdt_pkg::LOAD_RST);
		rchk(wdt_pkg::OFF_CTRL, wdt_pkg::ZERO_WORD);
		xfer(1'b0, 12'h028, 32'h0);
		chk({rd_v[30:0], err_v}, 32'h1);
		xfer(1'b1, wdt_pkg::OFF_CTRL, 32'h1);
		rchk(wdt_pkg::OFF_CTRL, 32'h1);
		xfer(1'b1, wdt_pkg::OFF_LOAD, 32'h28);
		xfer(1'b1, wdt_pkg::OFF_IMASK, 32'h3);
		xfer(1'b1, wdt_pkg::OFF_CTRL, 32'h4);
		rchk(wdt_pkg::OFF_CTRL, 32'h5);
		rchk(wdt_pkg::OFF_LOAD, 32'h28);
		xfer(1'b0, wdt_pkg::OFF_VALUE, 32'h0);
		chk(32'(rd_v < 32'h28), 32'h1);
		repeat (100) if (wdt_irq !== 1'b1) @(posedge clock);
		chk(32'(wdt_irq), 32'h1);
		rchk(wdt_pkg::OFF_RIS, 32'h1);
		xfer(1'b1, wdt_pkg::OFF_IMASK, 32'h0);
		repeat (2) @(posedge clock);
		chk(32'(wdt_irq), 32'h0);
		rchk(wdt_pkg::OFF_MIS, 32'h1);
		xfer(1'b1, wdt_pkg::OFF_IMASK, 32'h3);
		xfer(1'b1, wdt_pkg::OFF_ICR, 32'h0);
		rchk(wdt_pkg::OFF_RIS, wdt_pkg::ZERO_WORD);
		chk(32'(wdt_irq), 32'h0);
		xfer(1'b1, wdt_pkg::OFF_STATUS, 32'h3);
		xfer(1'b1, wdt_pkg::OFF_LOAD, wdt_pkg::ZERO_WORD);
		rchk(wdt_pkg::OFF_RIS, 32'h1);
		xfer(1'b1, wdt_pkg::OFF_LOAD, 32'h3e8);
		xfer(1'b0, wdt_pkg::OFF_VALUE, 32'h0);
		chk(32'(rd_v > 32'h3d0 && rd_v < 32'h3e8), 32'h1);
		xfer(1'b1, wdt_pkg::OFF_STALL, 32'h1);
		debug_halt <= 1'b1;
		xfer(1'b0, wdt_pkg::OFF_VALUE, 32'h0);
		rd_s = rd_v;
		rchk(wdt_pkg::OFF_VALUE, rd_s);
		debug_halt <= 1'b0;
		xfer(1'b0, wdt_pkg::OFF_VALUE, 32'h0);
		chk(32'(rd_v < rd_s), 32'h1);
		xfer(1'b1, wdt_pkg::OFF_LOCK, wdt_pkg::ZERO_WORD);
		rchk(wdt_pkg::OFF_LOCK, 32'h1);
		xfer(1'b1, wdt_pkg::OFF_LOAD, 32'h5);
		rchk(wdt_pkg::OFF_LOAD, 32'h3e8);
		xfer(1'b1, wdt_pkg::OFF_CTRL, 32'h7);
		rchk(wdt_pkg::OFF_CTRL, 32'h5);
		xfer(1'b1, wdt_pkg::OFF_LOCK, wdt_pkg::UNLOCK_KEY);
		rchk(wdt_pkg::OFF_LOCK, wdt_pkg::ZERO_WORD);
		xfer(1'b1, wdt_pkg::OFF_CTRL, 32'h7);
		rchk(wdt_pkg::OFF_CTRL, 32'h7);
		xfer(1'b1, wdt_pkg::OFF_CTRL, 32'h5);
		rchk(wdt_pkg::OFF_CTRL, 32'h5);
		xfer(1'b1, wdt_pkg::OFF_LOAD, 32'h14);
		repeat (60) @(posedge clock);
		chk(32'(wdt_sys_reset), 32'h0);
		xfer(1'b1, wdt_pkg::OFF_CTRL, 32'h7);
		repeat (60) if (wdt_sys_reset !== 1'b1) @(posedge clock);
		chk(32'(wdt_sys_reset), 32'h1);
		xfer(1'b0, wdt_pkg::OFF_STATUS, 32'h0);
		chk(32'(rd_v[1]), 32'h1);
		tally_and_finish();
	end
endmodule
